// ==== hw/rhgs_pkg.sv ====
package rhgs_pkg;
  // ==========================================
  // Timing
  localparam int CLK_HZ = 250_000_000;
  localparam int CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int ACK_TIMEOUT_S = 4;
  localparam int ACK_TIMEOUT_CYC = ACK_TIMEOUT_S * CLK_HZ;
  localparam int PWR_CYCLE_US = 1000;
  localparam int PWR_CYCLE_CYC = PWR_CYCLE_US * CLK_PER_US;
  localparam int PLT_HOLD_US = 1;
  localparam int PLT_HOLD_CYC = PLT_HOLD_US * CLK_PER_US;
  localparam int TMR_W = 32;

  // ==========================================
  // Register map (word indices, byte address = 4 * index)
  localparam int ADDR_W = 14;
  localparam logic [11:0] RSTCTL_IDX = 12'hcf9;
  localparam logic [11:0] CFG_IDX = 12'h000;
  localparam logic [11:0] STAT_IDX = 12'h001;
  localparam logic [7:0] RSTCTL_RST = 8'h00;
  localparam logic [7:0] RSTCTL_HOST = 8'h06;
  localparam logic [7:0] RSTCTL_HOSTPC = 8'h0e;
  localparam int RSTCTL_GO_BIT = 2;
  localparam int RSTCTL_PC_BIT = 3;
  localparam logic [2:0] CFG_RST = 3'h0;
  localparam int CFG_GLB_BIT = 0;
  localparam int CFG_S5GPIO_BIT = 1;
  localparam int CFG_LANGPIO_BIT = 2;

  // ==========================================
  // Pending trigger slots, least severe first
  localparam int PEND_HOST = 0;
  localparam int PEND_HOSTPC = 1;
  localparam int PEND_GLB = 2;
  localparam int PEND_S5 = 3;
  localparam int PEND_W = 4;

  typedef enum logic [1:0] {
    RHGS_SLP_S0, RHGS_SLEEP_S3_OUT_N, RHGS_SLEEP_S4_OUT_N, RHGS_SLEEP_S5_OUT_N
  } rhgs_slp_t;

  typedef enum logic [2:0] {
    RT_NONE, RT_HOST, RT_HOSTPC, RT_GLOBAL, RT_S5
  } rhgs_rtype_t;

  typedef enum logic [1:0] {
    SMB_MSG_NONE, SMB_MSG_PC, SMB_MSG_NOPC, SMB_MSG_OFF
  } rhgs_smb_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } rhgs_avm_req_t;

  typedef struct packed {
    logic s3_n;
    logic s4_n;
    logic s5_n;
    logic mgmt_n;
    logic lan_n;
  } rhgs_sleep_t;
endpackage

// ==== hw/rhgs_timer.sv ====
`timescale 1ns/10ps
module rhgs_timer
  import rhgs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Control
  input wire logic start_i,
  input wire logic clear_i,
  input wire logic [TMR_W-1:0] len_i,
  // Status
  output logic done_o
);
  logic [TMR_W-1:0] cnt_r;
  logic run_r;
  logic done_r;

  // Clear has priority so an acknowledge can never be overtaken
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      done_r <= 1'b0;
    end else if (clear_i) begin
      run_r <= 1'b0;
      done_r <= 1'b0;
    end else if (start_i) begin
      cnt_r <= len_i - 1'b1;
      run_r <= 1'b1;
      done_r <= 1'b0;
    end else if (run_r && cnt_r == '0) begin
      run_r <= 1'b0;
      done_r <= 1'b1;
    end else begin
      cnt_r <= run_r ? cnt_r - 1'b1 : cnt_r;
      done_r <= 1'b0;
    end
  end

  assign done_o = done_r;
endmodule

// ==== hw/rhgs_classify.sv ====
`timescale 1ns/10ps
module rhgs_classify
  import rhgs_pkg::*;
(
  // Pending triggers
  input wire logic [PEND_W-1:0] pend_i,
  // Most severe type
  output rhgs_rtype_t type_o
);
  always_comb begin
    if (pend_i[PEND_S5]) begin
      type_o = RT_S5;
    end else if (pend_i[PEND_GLB]) begin
      type_o = RT_GLOBAL;
    end else if (pend_i[PEND_HOSTPC]) begin
      type_o = RT_HOSTPC;
    end else if (pend_i[PEND_HOST]) begin
      type_o = RT_HOST;
    end else begin
      type_o = RT_NONE;
    end
  end
endmodule

// ==== hw/rhgs_top.sv ====
// Local design decision: the Avalon-MM register port.
`timescale 1ns/10ps
// What this block does
// - A host reset in S0 first sends a reset warning to the processor.
// - On acknowledge, drive platform_reset_n low.
// - Platform reset proceeds even if no acknowledge ever comes.
// - No acknowledge within four seconds escalates to global reset with power cycle.
// - While platform reset is low, the reset warning stays low.
// - Global reset resets both partitions but keeps reset-control state.
// - After global reset, power returns when the power-cycle period ends.
// - Straight-to-S5 turns off S3, S4, mgmt wells, and S5, LAN unless GPIO.
// - After straight-to-S5, host stays off until a wake event.
// - Write 0Eh with global select 0 gives host reset with power cycle.
// - Write 06h with global select 0 gives host reset without power cycle.
// - Write 06h or 0Eh with global select 1 gives global reset.
// - System reset request picks host reset type from control bit 3.
// - SMBus messages give host reset with or without cycle, or S5.
// - Second watchdog expiry gives host reset without power cycle.
// - Core power-good loss in S0 or deep-sleep power-good loss gives global reset.
// - System power-good loss in S0 gives global reset.
// - Processor thermal trip goes straight to S5 with platform reset low.
// - Internal catastrophic temperature goes straight to S5.
// - Host reset without power cycle in S3, S4 or S5 is dropped.
// - Global reset skips the warning and starts at once.
module rhgs_top
  import rhgs_pkg::*;
#(
  parameter int unsigned ACK_TIMEOUT_CYCLES = ACK_TIMEOUT_CYC,
  parameter int unsigned PWR_CYCLE_CYCLES = PWR_CYCLE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Avalon-MM slave
  input rhgs_avm_req_t avm_i,
  output logic [31:0] avm_readdata_o,
  output logic avm_waitrequest_o,
  // Reset triggers
  input wire logic system_reset_request_n_i,
  input wire logic core_power_good_i,
  input wire logic deep_sleep_well_power_good_i,
  input wire logic system_power_good_i,
  input wire logic processor_thermal_trip_n_i,
  input wire logic cat_temp_i,
  input wire logic smb_msg_valid_i,
  input rhgs_smb_t smb_msg_code_i,
  input wire logic system_health_watchdog_expire_i,
  // Power state and wake
  input rhgs_slp_t sleep_state_i,
  input wire logic wake_event_i,
  // Processor handshake
  output logic reset_warn_o,
  input wire logic reset_ack_i,
  // Reset and power outputs
  output logic platform_reset_n_o,
  output logic management_partition_reset_n_o,
  output logic sleep_s3_out_n_o,
  output logic sleep_s4_out_n_o,
  output logic sleep_s5_out_n_o,
  output logic sleep_mgmt_out_n_o,
  output logic sleep_lan_out_n_o
);
  // ==========================================
  // Declarations
  typedef enum logic [2:0] {ST_IDLE, ST_WARN, ST_PLT, ST_PCYC, ST_S5} rhgs_state_t;

  localparam int LVL_W = 6;

  rhgs_state_t state_r, state_nxt;
  rhgs_rtype_t cur_type_r, cur_type_nxt, cls;
  logic [PEND_W-1:0] pend_r, trig, pend_clr;
  logic [7:0] reset_control_register_r;
  logic [2:0] cfg_r;
  logic escalated_r, escalated_nxt;
  logic wdt_seen_r;
  logic [LVL_W-1:0] lvl, lvl_prev_r, lvl_fall;
  logic waitreq_r;
  logic [31:0] rdata_r;
  logic [11:0] idx;
  logic wr_fire;
  logic rc_go;
  logic in_s0;
  logic ack_start, ack_clr, ack_done;
  logic ph_start, ph_done;
  logic [TMR_W-1:0] ph_len;
  rhgs_sleep_t slp_r, slp_nxt;
  logic plt_n_r, mgmt_rst_n_r, warn_r;

  assign idx = avm_i.address[ADDR_W-1:2];
  assign in_s0 = (sleep_state_i == RHGS_SLP_S0);

  // ==========================================
  // Avalon-MM slave: one wait cycle, then answer
  assign wr_fire = avm_i.write && !waitreq_r;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      waitreq_r <= 1'b1;
    end else if (waitreq_r && (avm_i.read || avm_i.write)) begin
      waitreq_r <= 1'b0;
    end else begin
      waitreq_r <= 1'b1;
    end
  end

  // Unmapped reads return zero, unmapped writes vanish
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_r <= '0;
    end else if (waitreq_r && avm_i.read) begin
      case (idx)
        RSTCTL_IDX: rdata_r <= 32'(reset_control_register_r);
        CFG_IDX: rdata_r <= 32'(cfg_r);
        STAT_IDX: rdata_r <= 32'({wdt_seen_r, escalated_r, cur_type_r, state_r});
        default: rdata_r <= '0;
      endcase
    end
  end

  // Control state lives in the always-on well; no reset type clears it
  assign rc_go = wr_fire && idx == RSTCTL_IDX && avm_i.byteenable[0] &&
                 (avm_i.writedata[7:0] == RSTCTL_HOST ||
                  avm_i.writedata[7:0] == RSTCTL_HOSTPC);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      reset_control_register_r <= RSTCTL_RST;
    end else if (wr_fire && idx == RSTCTL_IDX && avm_i.byteenable[0]) begin
      reset_control_register_r <= avm_i.writedata[7:0];
      reset_control_register_r[RSTCTL_GO_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cfg_r <= CFG_RST;
    end else if (wr_fire && idx == CFG_IDX && avm_i.byteenable[0]) begin
      cfg_r <= avm_i.writedata[2:0];
    end
  end

  // ==========================================
  // Trigger detection
  // Previous levels start at zero, so a rail already low at reset never fires
  assign lvl = {system_reset_request_n_i, core_power_good_i,
                deep_sleep_well_power_good_i, system_power_good_i,
                processor_thermal_trip_n_i, ~cat_temp_i};
  assign lvl_fall = lvl_prev_r & ~lvl;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      lvl_prev_r <= '0;
    end else begin
      lvl_prev_r <= lvl;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wdt_seen_r <= 1'b0;
    end else if (system_health_watchdog_expire_i) begin
      wdt_seen_r <= !wdt_seen_r;
    end
  end

  always_comb begin
    trig = '0;
    if (rc_go) begin
      if (cfg_r[CFG_GLB_BIT]) begin
        trig[PEND_GLB] = 1'b1;
      end else if (avm_i.writedata[7:0] == RSTCTL_HOSTPC) begin
        trig[PEND_HOSTPC] = 1'b1;
      end else begin
        trig[PEND_HOST] = 1'b1;
      end
    end
    if (lvl_fall[5]) begin
      if (reset_control_register_r[RSTCTL_PC_BIT]) begin
        trig[PEND_HOSTPC] = 1'b1;
      end else begin
        trig[PEND_HOST] = 1'b1;
      end
    end
    if (smb_msg_valid_i) begin
      case (smb_msg_code_i)
        SMB_MSG_PC: trig[PEND_HOSTPC] = 1'b1;
        SMB_MSG_NOPC: trig[PEND_HOST] = 1'b1;
        SMB_MSG_OFF: trig[PEND_S5] = 1'b1;
        default: ;
      endcase
    end
    if (system_health_watchdog_expire_i && wdt_seen_r) begin
      trig[PEND_HOST] = 1'b1;
    end
    if ((lvl_fall[4] && in_s0) || lvl_fall[3]) begin
      trig[PEND_GLB] = 1'b1;
    end
    if (lvl_fall[2] && in_s0) begin
      trig[PEND_GLB] = 1'b1;
    end
    if (lvl_fall[1]) begin
      trig[PEND_S5] = 1'b1;
    end
    if (lvl_fall[0]) begin
      trig[PEND_S5] = 1'b1;
    end
  end

  // A new trigger in the accept cycle survives the clear
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pend_r <= '0;
    end else begin
      pend_r <= trig | (pend_r & ~pend_clr);
    end
  end

  rhgs_classify u_classify (
    .pend_i(pend_r),
    .type_o(cls)
  );

  // ==========================================
  // Timers
  rhgs_timer u_ack_timer (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .start_i(ack_start),
    .clear_i(ack_clr),
    .len_i(TMR_W'(ACK_TIMEOUT_CYCLES)),
    .done_o(ack_done)
  );

  rhgs_timer u_phase_timer (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .start_i(ph_start),
    .clear_i(1'b0),
    .len_i(ph_len),
    .done_o(ph_done)
  );

  // ==========================================
  // Sequencer
  always_comb begin
    state_nxt = state_r;
    cur_type_nxt = cur_type_r;
    escalated_nxt = escalated_r;
    pend_clr = '0;
    ack_start = 1'b0;
    ack_clr = 1'b0;
    ph_start = 1'b0;
    ph_len = TMR_W'(PLT_HOLD_CYC);
    case (state_r)
      ST_IDLE: begin
        if (cls != RT_NONE) begin
          pend_clr = '1;
          cur_type_nxt = cls;
          escalated_nxt = 1'b0;
          case (cls)
            RT_S5: begin
              state_nxt = ST_S5;
            end
            RT_GLOBAL: begin
              state_nxt = ST_PCYC;
              ph_start = 1'b1;
              ph_len = TMR_W'(PWR_CYCLE_CYCLES);
            end
            RT_HOSTPC: begin
              // Software-entered sleep: reset without the warning exchange
              if (in_s0) begin
                state_nxt = ST_WARN;
                ack_start = 1'b1;
              end else begin
                state_nxt = ST_PLT;
                ph_start = 1'b1;
              end
            end
            default: begin
              if (in_s0) begin
                state_nxt = ST_WARN;
                ack_start = 1'b1;
              end else begin
                cur_type_nxt = cur_type_r;
              end
            end
          endcase
        end
      end
      ST_WARN: begin
        if (reset_ack_i) begin
          state_nxt = ST_PLT;
          ack_clr = 1'b1;
          ph_start = 1'b1;
        end else if (ack_done) begin
          state_nxt = ST_PCYC;
          cur_type_nxt = RT_GLOBAL;
          escalated_nxt = 1'b1;
          ph_start = 1'b1;
          ph_len = TMR_W'(PWR_CYCLE_CYCLES);
        end
      end
      ST_PLT: begin
        if (ph_done) begin
          if (cur_type_r == RT_HOSTPC) begin
            state_nxt = ST_PCYC;
            ph_start = 1'b1;
            ph_len = TMR_W'(PWR_CYCLE_CYCLES);
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_PCYC: begin
        if (ph_done) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_S5: begin
        if (wake_event_i) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_r <= ST_IDLE;
      cur_type_r <= RT_NONE;
      escalated_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cur_type_r <= cur_type_nxt;
      escalated_r <= escalated_nxt;
    end
  end

  // ==========================================
  // Outputs, registered from the next state so they line up with state_r
  always_comb begin
    slp_nxt = '1;
    if (state_nxt == ST_PCYC) begin
      slp_nxt.s3_n = 1'b0;
      slp_nxt.s4_n = 1'b0;
      slp_nxt.mgmt_n = (cur_type_nxt != RT_GLOBAL);
    end
    if (state_nxt == ST_S5) begin
      slp_nxt.s3_n = 1'b0;
      slp_nxt.s4_n = 1'b0;
      slp_nxt.mgmt_n = 1'b0;
      slp_nxt.s5_n = cfg_r[CFG_S5GPIO_BIT];
    end
    // LAN rail follows the host or mgmt well; in S5 a GPIO pin is left high
    slp_nxt.lan_n = slp_nxt.s3_n | slp_nxt.mgmt_n |
                    (state_nxt == ST_S5 && cfg_r[CFG_LANGPIO_BIT]);
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      slp_r <= '1;
      plt_n_r <= 1'b0;
      mgmt_rst_n_r <= 1'b0;
      warn_r <= 1'b0;
    end else begin
      slp_r <= slp_nxt;
      plt_n_r <= !(state_nxt inside {ST_PLT, ST_PCYC, ST_S5});
      mgmt_rst_n_r <= !(state_nxt == ST_S5 ||
                        (state_nxt == ST_PCYC && cur_type_nxt == RT_GLOBAL));
      warn_r <= (state_nxt == ST_WARN);
    end
  end

  assign avm_readdata_o = rdata_r;
  assign avm_waitrequest_o = waitreq_r;
  assign reset_warn_o = warn_r;
  assign platform_reset_n_o = plt_n_r;
  assign management_partition_reset_n_o = mgmt_rst_n_r;
  assign sleep_s3_out_n_o = slp_r.s3_n;
  assign sleep_s4_out_n_o = slp_r.s4_n;
  assign sleep_s5_out_n_o = slp_r.s5_n;
  assign sleep_mgmt_out_n_o = slp_r.mgmt_n;
  assign sleep_lan_out_n_o = slp_r.lan_n;

  // ==========================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_warn_ack;
    state_r == ST_WARN && reset_ack_i;
  endsequence

  sequence s_warn_timeout;
    state_r == ST_WARN && !reset_ack_i && ack_done;
  endsequence

  AST_ACCEPT_WARNS: assert property (
    (state_r == ST_IDLE && cls == RT_HOST && in_s0) |=> reset_warn_o && platform_reset_n_o)
    else $error("host reset did not start with a warning");

  AST_ACK_ASSERTS_PLT: assert property (
    s_warn_ack |=> !platform_reset_n_o && !reset_warn_o)
    else $error("acknowledge did not assert platform reset");

  AST_TIMEOUT_ESCALATES: assert property (
    s_warn_timeout |=> state_r == ST_PCYC && cur_type_r == RT_GLOBAL &&
                       !management_partition_reset_n_o)
    else $error("ack timeout did not escalate to global reset");

  AST_PLT_QUIET: assert property (
    !platform_reset_n_o |-> !reset_warn_o)
    else $error("warning active during platform reset");

  AST_PCYC_RETURN: assert property (
    (state_r == ST_PCYC && ph_done) |=> sleep_s3_out_n_o && platform_reset_n_o)
    else $error("power not restored after power cycle");

  AST_S5_WELLS_OFF: assert property (
    state_r == ST_S5 |-> !sleep_s3_out_n_o && !sleep_s4_out_n_o &&
                         !sleep_mgmt_out_n_o && !platform_reset_n_o)
    else $error("wells still on in S5");

  AST_WRITE_06: assert property (
    (rc_go && !cfg_r[CFG_GLB_BIT] && avm_i.writedata[7:0] == RSTCTL_HOST)
    |=> pend_r[PEND_HOST])
    else $error("06h write did not request host reset");

  AST_DROP_IN_SX: assert property (
    (state_r == ST_IDLE && cls == RT_HOST && !in_s0) |=>
    state_r == ST_IDLE && platform_reset_n_o && !reset_warn_o)
    else $error("host reset not dropped in sleep state");

  AST_GLOBAL_NO_WARN: assert property (
    (state_r == ST_IDLE && cls == RT_GLOBAL) |=> !reset_warn_o && !platform_reset_n_o)
    else $error("global reset sent a warning");

  AST_S5_WINS: assert property (
    (state_r == ST_IDLE && pend_r[PEND_S5]) |=> state_r == ST_S5)
    else $error("straight-to-S5 not served first");
endmodule

// ==== verification/rhgs_cpu_model.sv ====
`timescale 1ns/10ps
// ==========================================
// Processor side of the reset warning handshake
module rhgs_cpu_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Handshake and test controls
  input wire logic reset_warn_i,
  input wire logic mute_i,
  input wire logic [7:0] delay_i,
  output logic reset_ack_o
);
  logic [7:0] cnt_r;
  // Ack after the memory flush delay; a muted processor never answers
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !reset_warn_i) begin
      cnt_r <= 8'h00;
      reset_ack_o <= 1'b0;
    end else begin
      if (cnt_r != 8'hff) cnt_r <= cnt_r + 8'h01;
      reset_ack_o <= !mute_i && (cnt_r >= delay_i);
    end
  end
endmodule

// ==== verification/test_host_global_reset_sequencer.sv ====
`timescale 1ns/10ps
module test_host_global_reset_sequencer
  import rhgs_pkg::*;
;
  // ==========================================
  // Harness
  localparam int ACK_CYC = 50;
  localparam logic [13:0] A_CTL = {RSTCTL_IDX, 2'b00};
  localparam logic [13:0] A_CFG = {CFG_IDX, 2'b00};
  localparam logic [13:0] A_STAT = {STAT_IDX, 2'b00};
  logic clk_i, reset_n_i, waitreq, sysrst_n, core_pg, dsw_pg, sys_pg, trip_n, cat_temp;
  logic smb_v, wdt, wake, warn, ack, mute, plt_n, mgmt_n, s3_n, s4_n, s5_n, mg_n, lan_n;
  logic [31:0] rdata;
  logic [7:0] dly;
  rhgs_avm_req_t avm;
  rhgs_smb_t smb_code;
  rhgs_slp_t slp;
  int fails, samples_checked, cycles;

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  rhgs_top #(.ACK_TIMEOUT_CYCLES(ACK_CYC), .PWR_CYCLE_CYCLES(20)) uut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .avm_i(avm), .avm_readdata_o(rdata),
    .avm_waitrequest_o(waitreq), .system_reset_request_n_i(sysrst_n),
    .core_power_good_i(core_pg), .deep_sleep_well_power_good_i(dsw_pg),
    .system_power_good_i(sys_pg), .processor_thermal_trip_n_i(trip_n),
    .cat_temp_i(cat_temp), .smb_msg_valid_i(smb_v), .smb_msg_code_i(smb_code),
    .system_health_watchdog_expire_i(wdt), .sleep_state_i(slp), .wake_event_i(wake),
    .reset_warn_o(warn), .reset_ack_i(ack), .platform_reset_n_o(plt_n),
    .management_partition_reset_n_o(mgmt_n), .sleep_s3_out_n_o(s3_n),
    .sleep_s4_out_n_o(s4_n), .sleep_s5_out_n_o(s5_n), .sleep_mgmt_out_n_o(mg_n),
    .sleep_lan_out_n_o(lan_n)
  );

  rhgs_cpu_model cpu (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .reset_warn_i(warn), .mute_i(mute),
    .delay_i(dly), .reset_ack_o(ack)
  );

  // Whole run needs about 3k cycles; a hang stops at 40k
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      wrap_up();
    end
  end

  // ==========================================
  // Shared tasks
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [13:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_i);
    avm.address <= a;
    avm.read <= !wr;
    avm.write <= wr;
    avm.writedata <= d;
    // No fixed latency assumed; only the bench timeout ends a stuck wait
    do begin
      @(posedge clk_i);
    end while (waitreq !== 1'b0);
    q = rdata;
    avm.read <= 1'b0;
    avm.write <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h0, d}, q);
  endtask

  task automatic rd(input logic [13:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask

  task automatic smb(input rhgs_smb_t c);
    @(posedge clk_i);
    smb_v <= 1'b1;
    smb_code <= c;
    @(posedge clk_i);
    smb_v <= 1'b0;
  endtask

  task automatic quiet();
    repeat (30) @(negedge clk_i);
    check(32'({warn, plt_n, mgmt_n}), 32'h3);
    @(posedge clk_i);
  endtask

  task automatic wait_idle();
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      rd(A_STAT, q);
      n++;
    end while (q[2:0] !== 3'h0 && n < 300);
    @(negedge clk_i);
    check(32'({plt_n, mgmt_n, s3_n, s4_n, s5_n, mg_n, lan_n, warn}), 32'hfe);
    @(posedge clk_i);
  endtask

  // Waits for a sequence to start, checks its kind and outputs, then lets it finish
  task automatic expect_seq(input rhgs_rtype_t t, input logic [2:0] cfg);
    logic [31:0] q;
    logic host;
    int n;
    host = (t == RT_HOST) || (t == RT_HOSTPC);
    n = 0;
    while (warn !== 1'b1 && plt_n !== 1'b0 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    check(32'(warn), 32'(host));
    while (warn === 1'b1 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    if (host) check(32'({plt_n, s3_n, mgmt_n}), 32'h3);
    rd(A_STAT, q);
    check(32'(q[5:3]), 32'(t));
    if (t == RT_GLOBAL) check(32'({plt_n, mgmt_n, s3_n, s4_n, warn}), 32'h0);
    if (t == RT_S5) begin
      check(32'({plt_n, mgmt_n, s3_n, s4_n, mg_n, s5_n, lan_n}), 32'({cfg[1], cfg[2]}));
      repeat (60) @(negedge clk_i);
      check(32'({plt_n, s3_n}), 32'h0);
      @(posedge clk_i);
      wake <= 1'b1;
      @(posedge clk_i);
      wake <= 1'b0;
    end
    if (t == RT_HOSTPC) begin
      n = 0;
      while (s3_n !== 1'b0 && n < 400) begin
        @(negedge clk_i);
        n++;
      end
      check(32'({s3_n, mgmt_n}), 32'h1);
    end
    wait_idle();
  endtask

  // ==========================================
  // Scenarios
  task automatic t_codes();
    logic [31:0] q;
    wr(A_CFG, 8'h00);
    wr(A_CTL, RSTCTL_HOST);
    expect_seq(RT_HOST, 3'h0);
    dly <= 8'h05;
    wr(A_CTL, RSTCTL_HOSTPC);
    expect_seq(RT_HOSTPC, 3'h0);
    wr(A_CFG, 8'h01);
    wr(A_CTL, RSTCTL_HOST);
    expect_seq(RT_GLOBAL, 3'h0);
    wr(A_CTL, RSTCTL_HOSTPC);
    expect_seq(RT_GLOBAL, 3'h0);
    rd(A_CTL, q);
    check(q, 32'h0a);
    wr(A_CFG, 8'h00);
  endtask

  task automatic t_sysrst(input logic [7:0] ctl, input rhgs_rtype_t t);
    wr(A_CTL, ctl);
    @(posedge clk_i);
    sysrst_n <= 1'b0;
    @(posedge clk_i);
    sysrst_n <= 1'b1;
    expect_seq(t, 3'h0);
  endtask

  task automatic t_smb();
    smb(SMB_MSG_PC);
    expect_seq(RT_HOSTPC, 3'h0);
    smb(SMB_MSG_NOPC);
    expect_seq(RT_HOST, 3'h0);
    smb(SMB_MSG_OFF);
    expect_seq(RT_S5, 3'h0);
    wr(A_CFG, 8'h02);
    smb(SMB_MSG_OFF);
    expect_seq(RT_S5, 3'h2);
    wr(A_CFG, 8'h00);
  endtask

  // First expiry only arms; the second one must start a host reset
  task automatic t_wdt();
    @(posedge clk_i);
    wdt <= 1'b1;
    @(posedge clk_i);
    wdt <= 1'b0;
    quiet();
    wdt <= 1'b1;
    @(posedge clk_i);
    wdt <= 1'b0;
    expect_seq(RT_HOST, 3'h0);
  endtask

  task automatic t_power();
    @(posedge clk_i);
    core_pg <= 1'b0;
    expect_seq(RT_GLOBAL, 3'h0);
    core_pg <= 1'b1;
    dsw_pg <= 1'b0;
    expect_seq(RT_GLOBAL, 3'h0);
    dsw_pg <= 1'b1;
    sys_pg <= 1'b0;
    expect_seq(RT_GLOBAL, 3'h0);
    sys_pg <= 1'b1;
    slp <= RHGS_SLEEP_S3_OUT_N;
    core_pg <= 1'b0;
    quiet();
    core_pg <= 1'b1;
    wr(A_CTL, RSTCTL_HOST);
    quiet();
    wr(A_CTL, RSTCTL_HOSTPC);
    repeat (4) @(negedge clk_i);
    check(32'({warn, plt_n, s3_n}), 32'h1);
    wait_idle();
    slp <= RHGS_SLP_S0;
  endtask

  task automatic t_therm();
    @(posedge clk_i);
    trip_n <= 1'b0;
    @(posedge clk_i);
    trip_n <= 1'b1;
    expect_seq(RT_S5, 3'h0);
    cat_temp <= 1'b1;
    @(posedge clk_i);
    cat_temp <= 1'b0;
    expect_seq(RT_S5, 3'h0);
    cat_temp <= 1'b1;
    smb_v <= 1'b1;
    smb_code <= SMB_MSG_NOPC;
    @(posedge clk_i);
    cat_temp <= 1'b0;
    smb_v <= 1'b0;
    expect_seq(RT_S5, 3'h0);
    quiet();
  endtask

  task automatic t_esc();
    logic [31:0] q;
    int n;
    mute <= 1'b1;
    wr(A_CTL, RSTCTL_HOST);
    n = 0;
    while (warn !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    n = 0;
    while (mgmt_n !== 1'b0 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    check(32'(n >= ACK_CYC - 4 && n <= ACK_CYC + 4), 32'h1);
    check(32'({plt_n, s3_n, warn}), 32'h0);
    rd(A_STAT, q);
    check(32'(q[6]), 32'h1);
    mute <= 1'b0;
    wait_idle();
  endtask

  // ==========================================
  // Main sequence
  initial begin
    logic [31:0] q;
    reset_n_i = 1'b0;
    avm = '0;
    avm.byteenable = 4'hf;
    {sysrst_n, core_pg, dsw_pg, sys_pg, trip_n} = 5'h1f;
    {cat_temp, smb_v, wdt, wake, mute} = 5'h00;
    smb_code = SMB_MSG_NONE;
    slp = RHGS_SLP_S0;
    dly = 8'h00;
    fails = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (12) @(posedge clk_i);
    check(32'({plt_n, mgmt_n, warn, s3_n, s4_n, s5_n, mg_n, lan_n, waitreq}), 32'h3f);
    reset_n_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    check(32'({plt_n, mgmt_n}), 32'h3);
    rd(A_CTL, q);
    check(q, 32'(RSTCTL_RST));
    t_codes();
    t_sysrst(8'h00, RT_HOST);
    t_sysrst(8'h08, RT_HOSTPC);
    t_smb();
    t_wdt();
    t_power();
    t_therm();
    t_esc();
    wrap_up();
  end
endmodule
